// File: core/door_out_pkg.sv
/*
  Package for the door output and parking block: Wishbone register map,
  field positions, reset values, timing counts and the carrier structs.
  Assumes a 25 MHz system clock; positions are in millimetres.
*/
package door_out_pkg;

  // ===========================================================
  // register map (byte addresses, one word each)
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_THRESH = 8'h04;
  localparam logic [7:0] ADDR_PARK = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_POS = 8'h10;

  // ===========================================================
  // field positions of the config word
  localparam int CFG_AUX_MODE_LSB = 0;
  localparam int CFG_OPEN_MODE_BIT = 2;
  localparam int CFG_PARK_MODE_BIT = 3;
  localparam int CFG_POS_CTRL_BIT = 4;

  // ===========================================================
  // mode encodings
  localparam logic [1:0] AUX_OFF = 2'h0;
  localparam logic [1:0] AUX_OPENING = 2'h1;
  localparam logic [1:0] AUX_PERCENT = 2'h2;
  localparam logic [1:0] AUX_ERROR = 2'h3;
  localparam logic OPEN_NEED_CMD = 1'h0;
  localparam logic OPEN_ALWAYS = 1'h1;
  localparam logic PARK_SKATE_CLOSED = 1'h0;
  localparam logic PARK_SKATE_OPEN = 1'h1;
  localparam logic POSCTRL_FREE = 1'h0;
  localparam logic POSCTRL_HOLD = 1'h1;

  // ===========================================================
  // reset values and write limits of settings
  localparam logic [1:0] RST_AUX_MODE = AUX_ERROR;
  localparam logic RST_OPEN_MODE = OPEN_ALWAYS;
  localparam logic RST_PARK_MODE = PARK_SKATE_CLOSED;
  localparam logic RST_POS_CTRL = POSCTRL_FREE;
  localparam logic [6:0] RST_AUX_PCT = 7'h32;
  localparam logic [5:0] RST_OPEN_THR_MM = 6'h19;
  localparam logic [5:0] OPEN_THR_MIN_MM = 6'h05;
  localparam logic [5:0] OPEN_THR_MAX_MM = 6'h28;
  localparam logic [9:0] RST_DELAY_S = 10'h0f0;
  localparam logic [9:0] DELAY_MIN_S = 10'h005;
  localparam logic [9:0] DELAY_MAX_S = 10'h3e7;
  localparam logic [7:0] RST_SKATE_MM = 8'h14;
  localparam logic [7:0] SKATE_MIN_MM = 8'h05;
  localparam logic [7:0] SKATE_MAX_MM = 8'h96;
  localparam logic [4:0] RST_ERR_MM = 5'h0a;
  localparam logic [4:0] ERR_MIN_MM = 5'h02;
  localparam logic [4:0] ERR_MAX_MM = 5'h14;

  // ===========================================================
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int SECOND_S = 1;
  localparam int SECOND_CYC = SECOND_S * CLK_HZ;

  // ===========================================================
  // carriers
  typedef struct packed {
    logic [1:0] aux_mode;
    logic open_mode;
    logic park_mode;
    logic pos_ctrl;
    logic [6:0] aux_pct;
    logic [5:0] open_thr;
    logic [9:0] delay_s;
    logic [7:0] skate_mm;
    logic [4:0] err_mm;
  } settings_s;

  typedef struct packed {
    logic open_cmd;
    logic close_cmd;
    logic rsc_cmd;
    logic at_end_stop;
    logic opening;
    logic alarm;
    logic overheat;
  } door_in_s;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_CLOSED_PARK,
    PH_DELAY,
    PH_SKATE_OPENING,
    PH_SKATE_PARK,
    PH_SKATE_CLOSING,
    PH_DCS_OFF
  } phase_e;

endpackage

// File: core/door_output_park.sv
/*
  Door output signalling and closed-door parking control, with a classic
  Wishbone slave for its settings and status.
  Assumes door inputs and positions are synchronous to CLK_I; the motor
  drive outside follows the movement requests and the torque levels.
*/
// How it works
// - aux mode 0: relay always off
// - aux mode 1: relay on while opening
// - aux mode 2: relay on above percent
// - aux mode 3 default: alarm or overheat
// - open mode 0: open status needs command
// - open mode 1 default: status without command
// - open within 5..40 mm below learned
// - open needs quote and end stop
// - park mode 0 keeps skate closed
// - entry delay from close fall, 5..999 s
// - skate opens slowly by set distance
// - pushed open beyond limit: leave parking
// - position control 0: motor unpowered
// - position control 1: reduced torque hold
// - closed park holds torque, closed status
// - delay restarts phase 1 on close
// - skate opening goes to closing on close
// - open skate park: close goes closing
// - open command starts opening at once
`timescale 1ns/10ps
module door_output_park
  import door_out_pkg::*;
#(
  // clock cycles per second of the parking delay; lowered only to let
  // verification reach the later parking phases in a short run
  parameter int unsigned TICK_CYC = SECOND_CYC
)
(
  // clock, reset, enable
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  // wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // door signals
  input wire door_out_pkg::door_in_s DOOR_I,
  input wire logic [11:0] POSITION_I,
  input wire logic [11:0] LEARNED_OPEN_I,
  // outputs
  output logic AUX_RELAY_OUTPUT_O,
  output logic DOOR_OPEN_STATUS_O,
  output logic DOOR_CLOSED_STATUS_O,
  output logic SKATE_OPEN_REQ_O,
  output logic SKATE_CLOSE_REQ_O,
  output logic OPEN_REQ_O,
  output logic PARK_TORQUE_O,
  output logic HOLD_LOOP_O,
  output logic MOTOR_OFF_O
);
  import door_out_pkg::*;

  // ===========================================================
  // state
  typedef struct packed {
    settings_s cfg;
    phase_e phase;
    logic close_d;
    logic [24:0] tick;
    logic [9:0] secs;
    logic [11:0] park_pos;
    logic [31:0] dat;
    logic ack;
    logic aux;
    logic door_open_status;
    logic door_closed_status;
    logic skate_open;
    logic skate_close;
    logic open_req;
    logic torque;
    logic hold;
    logic motor_off;
  } state_s;

  state_s cur_ff;
  state_s nxt_ff;

  // ===========================================================
  // decoded door conditions
  logic [11:0] open_floor;
  logic [18:0] pct_pos;
  logic [18:0] pct_lim;
  logic near_open;
  logic closed_now;
  logic close_fall;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic skate_reached;
  logic pushed_open;
  logic tick_last;

  // ===========================================================
  // saturating clamp for written fields
  function automatic logic [31:0] clampv(input logic [31:0] v,
                                         input logic [31:0] lo,
                                         input logic [31:0] hi);
    logic [31:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  always_comb begin
    nxt_ff = cur_ff;
    open_floor = (LEARNED_OPEN_I > {6'h00, cur_ff.cfg.open_thr}) ?
                 LEARNED_OPEN_I - {6'h00, cur_ff.cfg.open_thr} : 12'h000;
    near_open = (POSITION_I >= open_floor) && DOOR_I.at_end_stop;
    // the skate rests at zero too, so zero is the only closed position
    closed_now = (POSITION_I == 12'h000);
    // edge against last cycle's sample of the close command
    close_fall = cur_ff.close_d && !DOOR_I.close_cmd;
    // cross-multiplied so the percentage needs no divider
    pct_pos = 19'(POSITION_I) * 19'd100;
    pct_lim = 19'(LEARNED_OPEN_I) * 19'(cur_ff.cfg.aux_pct);
    wr = CYC_I && STB_I && WE_I && !cur_ff.ack;
    wmask = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};
    wval = 32'h0;
    // skate travel counted from the reference taken at entry
    skate_reached = POSITION_I >= cur_ff.park_pos +
                    {4'h0, cur_ff.cfg.skate_mm};
    // push in the opening direction beyond the error limit
    pushed_open = POSITION_I > cur_ff.park_pos + {7'h0, cur_ff.cfg.err_mm};
    tick_last = cur_ff.tick == 25'(TICK_CYC - 1);

    // ==========================================================
    // wishbone: one wait state, ack dropped the cycle after
    // writes land at the taking edge, the same edge that raises ack
    nxt_ff.ack = CYC_I && STB_I && !cur_ff.ack;
    nxt_ff.dat = 32'h0;
    unique case (ADR_I)
      ADDR_CONFIG: begin
        wval = {27'h0, cur_ff.cfg.pos_ctrl, cur_ff.cfg.park_mode,
                cur_ff.cfg.open_mode, cur_ff.cfg.aux_mode};
        nxt_ff.dat = wval;
        if (wr) begin
          wval = (wval & ~wmask) | (DAT_I & wmask);
          nxt_ff.cfg.aux_mode = wval[CFG_AUX_MODE_LSB +: 2];
          nxt_ff.cfg.open_mode = wval[CFG_OPEN_MODE_BIT];
          nxt_ff.cfg.park_mode = wval[CFG_PARK_MODE_BIT];
          nxt_ff.cfg.pos_ctrl = wval[CFG_POS_CTRL_BIT];
        end
      end
      ADDR_THRESH: begin
        wval = {10'h0, cur_ff.cfg.open_thr, 9'h0, cur_ff.cfg.aux_pct};
        nxt_ff.dat = wval;
        if (wr) begin
          wval = (wval & ~wmask) | (DAT_I & wmask);
          nxt_ff.cfg.aux_pct = (wval[6:0] > 7'd100) ? 7'd100 : wval[6:0];
          nxt_ff.cfg.open_thr = 6'(clampv({26'h0, wval[21:16]},
            32'(OPEN_THR_MIN_MM), 32'(OPEN_THR_MAX_MM)));
        end
      end
      ADDR_PARK: begin
        wval = {3'h0, cur_ff.cfg.err_mm, cur_ff.cfg.skate_mm, 6'h0,
                cur_ff.cfg.delay_s};
        nxt_ff.dat = wval;
        if (wr) begin
          wval = (wval & ~wmask) | (DAT_I & wmask);
          nxt_ff.cfg.delay_s = 10'(clampv({22'h0, wval[9:0]},
            32'(DELAY_MIN_S), 32'(DELAY_MAX_S)));
          nxt_ff.cfg.skate_mm = 8'(clampv({24'h0, wval[23:16]},
            32'(SKATE_MIN_MM), 32'(SKATE_MAX_MM)));
          nxt_ff.cfg.err_mm = 5'(clampv({27'h0, wval[28:24]},
            32'(ERR_MIN_MM), 32'(ERR_MAX_MM)));
        end
      end
      ADDR_STATUS: begin
        nxt_ff.dat = {10'h0, cur_ff.motor_off, cur_ff.hold, cur_ff.torque,
                      cur_ff.open_req, cur_ff.skate_close, cur_ff.skate_open,
                      cur_ff.aux, cur_ff.secs, cur_ff.door_closed_status, cur_ff.door_open_status,
                      cur_ff.phase};
      end
      ADDR_POS: begin
        nxt_ff.dat = {4'h0, cur_ff.park_pos, 4'h0, POSITION_I};
      end
      default: begin
        nxt_ff.dat = 32'h0;
      end
    endcase

    // ==========================================================
    // aux relay
    unique case (cur_ff.cfg.aux_mode)
      AUX_OFF: nxt_ff.aux = 1'b0;
      AUX_OPENING: nxt_ff.aux = DOOR_I.opening;
      AUX_PERCENT: nxt_ff.aux = pct_pos > pct_lim;
      AUX_ERROR: nxt_ff.aux = DOOR_I.alarm || DOOR_I.overheat;
    endcase

    // ==========================================================
    // door open status
    // mode 0 keeps the status once earned while the door stays open
    if (!near_open) begin
      nxt_ff.door_open_status = 1'b0;
    end else if (cur_ff.cfg.open_mode == OPEN_ALWAYS) begin
      nxt_ff.door_open_status = 1'b1;
    end else if (DOOR_I.open_cmd) begin
      nxt_ff.door_open_status = 1'b1;
    end

    // ==========================================================
    // parking sequence
    // registered copy for the close edge
    nxt_ff.close_d = DOOR_I.close_cmd;
    nxt_ff.open_req = DOOR_I.open_cmd;
    nxt_ff.skate_open = 1'b0;
    nxt_ff.skate_close = 1'b0;
    nxt_ff.torque = 1'b0;
    nxt_ff.hold = 1'b0;
    nxt_ff.motor_off = 1'b0;
    if (DOOR_I.open_cmd) begin
      nxt_ff.phase = PH_IDLE;
      nxt_ff.door_closed_status = 1'b0;
    end else begin
      unique case (cur_ff.phase)
        PH_IDLE: begin
          nxt_ff.door_closed_status = 1'b0;
          // reduced speed held means a forced close, not parking
          if (closed_now && DOOR_I.close_cmd && !DOOR_I.rsc_cmd) begin
            nxt_ff.phase = PH_CLOSED_PARK;
            nxt_ff.door_closed_status = 1'b1;
          end
        end
        PH_CLOSED_PARK: begin
          nxt_ff.torque = 1'b1;
          nxt_ff.door_closed_status = 1'b1;
          // skate stays closed in mode 0
          if (close_fall && cur_ff.cfg.park_mode == PARK_SKATE_OPEN) begin
            nxt_ff.phase = PH_DELAY;
            nxt_ff.tick = 25'h0;
            nxt_ff.secs = 10'h0;
          end
        end
        PH_DELAY: begin
          // whole seconds are counted so secs compares with the setting
          nxt_ff.torque = 1'b1;
          nxt_ff.door_closed_status = 1'b1;
          if (DOOR_I.close_cmd) begin
            nxt_ff.phase = PH_CLOSED_PARK;
          end else if (cur_ff.secs >= cur_ff.cfg.delay_s) begin
            nxt_ff.phase = PH_SKATE_OPENING;
            nxt_ff.park_pos = POSITION_I;
          end else if (tick_last) begin
            nxt_ff.tick = 25'h0;
            nxt_ff.secs = cur_ff.secs + 10'h1;
          end else begin
            nxt_ff.tick = cur_ff.tick + 25'h1;
          end
        end
        PH_SKATE_OPENING: begin
          nxt_ff.door_closed_status = 1'b1;
          if (DOOR_I.close_cmd) begin
            nxt_ff.phase = PH_SKATE_CLOSING;
          end else if (skate_reached) begin
            nxt_ff.phase = PH_SKATE_PARK;
            nxt_ff.park_pos = POSITION_I;
          end else begin
            nxt_ff.skate_open = 1'b1;
          end
        end
        PH_SKATE_PARK: begin
          nxt_ff.door_closed_status = 1'b1;
          if (DOOR_I.close_cmd) begin
            nxt_ff.phase = PH_SKATE_CLOSING;
          end else if (pushed_open) begin
            nxt_ff.phase = PH_DCS_OFF;
            nxt_ff.door_closed_status = 1'b0;
          end else begin
            // drive mode only while staying, never on the way out
            // free panels
            nxt_ff.motor_off = cur_ff.cfg.pos_ctrl == POSCTRL_FREE;
            nxt_ff.hold = cur_ff.cfg.pos_ctrl == POSCTRL_HOLD;
          end
        end
        PH_SKATE_CLOSING: begin
          nxt_ff.door_closed_status = 1'b1;
          if (closed_now) begin
            nxt_ff.phase = PH_CLOSED_PARK;
          end else begin
            nxt_ff.skate_close = 1'b1;
          end
        end
        PH_DCS_OFF: begin
          // waits for a fresh command from the controller
          nxt_ff.door_closed_status = 1'b0;
          if (DOOR_I.close_cmd) begin
            nxt_ff.phase = PH_SKATE_CLOSING;
            nxt_ff.door_closed_status = 1'b0;
          end
        end
        default: begin
          nxt_ff.phase = PH_IDLE;
        end
      endcase
    end
  end

  // ce low freezes everything, the bus ack included
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      // settings return to their defaults
      cur_ff <= '{cfg: '{aux_mode: RST_AUX_MODE, open_mode: RST_OPEN_MODE,
                         park_mode: RST_PARK_MODE, pos_ctrl: RST_POS_CTRL,
                         aux_pct: RST_AUX_PCT, open_thr: RST_OPEN_THR_MM,
                         delay_s: RST_DELAY_S, skate_mm: RST_SKATE_MM,
                         err_mm: RST_ERR_MM},
                  phase: PH_IDLE, default: '0};
    end else if (CE_I) begin
      cur_ff <= nxt_ff;
    end
  end

  // ===========================================================
  // outputs come straight from the state register
  assign DAT_O = cur_ff.dat;
  assign ACK_O = cur_ff.ack;
  assign AUX_RELAY_OUTPUT_O = cur_ff.aux;
  assign DOOR_OPEN_STATUS_O = cur_ff.door_open_status;
  assign DOOR_CLOSED_STATUS_O = cur_ff.door_closed_status;
  assign SKATE_OPEN_REQ_O = cur_ff.skate_open;
  assign SKATE_CLOSE_REQ_O = cur_ff.skate_close;
  assign OPEN_REQ_O = cur_ff.open_req;
  assign PARK_TORQUE_O = cur_ff.torque;
  assign HOLD_LOOP_O = cur_ff.hold;
  assign MOTOR_OFF_O = cur_ff.motor_off;

endmodule

// File: tb/door_output_park_monitor.sv
/*
  Checker for the door output block; sees only its ports.
  Assumes the bench keeps CE_I high while bus and door traffic run.
*/
`timescale 1ns/10ps
module door_output_park_monitor
  import door_out_pkg::*;
(
  // clock, reset, bus
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic CE_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O,
  // door side
  input wire door_out_pkg::door_in_s DOOR_I,
  input wire logic [11:0] POSITION_I,
  input wire logic [11:0] LEARNED_OPEN_I,
  input wire logic DOOR_OPEN_STATUS_O,
  input wire logic DOOR_CLOSED_STATUS_O,
  input wire logic SKATE_OPEN_REQ_O,
  input wire logic OPEN_REQ_O,
  input wire logic PARK_TORQUE_O,
  input wire logic HOLD_LOOP_O,
  input wire logic MOTOR_OFF_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // ===========================================================
  // sequences
  // four samples cover the detour through skate closing
  sequence close_held;
    (CE_I && DOOR_I.close_cmd && !DOOR_I.open_cmd && !DOOR_I.rsc_cmd
      && POSITION_I == 12'h000)[*4];
  endsequence
  sequence open_taken;
    CE_I && DOOR_I.open_cmd;
  endsequence
  // ===========================================================
  // assertions
  chk_ack_pulse: assert property (ACK_O && CE_I |=> !ACK_O)
    else $error("ack held longer than one cycle");
  chk_ack_answer: assert property (CE_I && CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("bus request not acked in time");
  chk_open_follow: assert property (
    CE_I |=> OPEN_REQ_O == $past(DOOR_I.open_cmd))
    else $error("open request does not follow open command");
  chk_open_abort: assert property (
    open_taken |=> !PARK_TORQUE_O && !SKATE_OPEN_REQ_O && !HOLD_LOOP_O
      && !MOTOR_OFF_O)
    else $error("parking kept after open command");
  chk_close_park: assert property (
    close_held |-> PARK_TORQUE_O && DOOR_CLOSED_STATUS_O)
    else $error("closed parking torque missing");
  chk_torque_closed: assert property (
    PARK_TORQUE_O |-> DOOR_CLOSED_STATUS_O)
    else $error("torque phase without closed status");
  chk_hold_closed: assert property (
    HOLD_LOOP_O |-> DOOR_CLOSED_STATUS_O && !MOTOR_OFF_O)
    else $error("hold loop outside open skate parking");
  chk_free_closed: assert property (
    MOTOR_OFF_O |-> DOOR_CLOSED_STATUS_O && !PARK_TORQUE_O)
    else $error("motor off outside open skate parking");
  chk_skate_abort: assert property (
    SKATE_OPEN_REQ_O && CE_I && DOOR_I.close_cmd |=> !SKATE_OPEN_REQ_O)
    else $error("skate opening kept after close command");
  chk_open_zone: assert property (
    $rose(DOOR_OPEN_STATUS_O) |-> $past(DOOR_I.at_end_stop)
      && {1'b0, $past(POSITION_I)} + 13'h028 >= {1'b0, $past(LEARNED_OPEN_I)})
    else $error("open status outside open zone");
endmodule

bind door_output_park door_output_park_monitor u_mon (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CE_I(CE_I), .CYC_I(CYC_I),
  .STB_I(STB_I), .ACK_O(ACK_O), .DOOR_I(DOOR_I), .POSITION_I(POSITION_I),
  .LEARNED_OPEN_I(LEARNED_OPEN_I), .DOOR_OPEN_STATUS_O(DOOR_OPEN_STATUS_O),
  .DOOR_CLOSED_STATUS_O(DOOR_CLOSED_STATUS_O),
  .SKATE_OPEN_REQ_O(SKATE_OPEN_REQ_O), .OPEN_REQ_O(OPEN_REQ_O),
  .PARK_TORQUE_O(PARK_TORQUE_O), .HOLD_LOOP_O(HOLD_LOOP_O),
  .MOTOR_OFF_O(MOTOR_OFF_O));

// File: tb/lift_ctrl_model.sv
/*
  Behavioural lift main controller issuing open and close commands.
  Assumes the bench says when the car parks idle or wants the door open.
*/
`timescale 1ns/10ps
module lift_ctrl_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic parked_i,
  input wire logic want_open_i,
  output logic open_cmd_o,
  output logic close_cmd_o
);
  // close drops while parked or while the door is wanted open, and rises before any
  // trip; an open safety chain while parked raises no alarm here
  // close unless parked or wanting the door open
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      open_cmd_o <= 1'b0;
      close_cmd_o <= 1'b0;
    end else begin
      open_cmd_o <= want_open_i;
      close_cmd_o <= !want_open_i && !parked_i;
    end
  end
endmodule

// File: tb/door_output_and_parking_control_bench.sv
/*
  Self-checking bench for the door output and parking block.
  Assumes one bus wait cycle and outputs one cycle after their cause.
*/
`timescale 1ns/10ps
module door_output_and_parking_control_bench;
  import door_out_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [11:0] pos = 12'h000;
  logic parked = 1'b1, want_open = 1'b0, opn, cls;
  logic end_stop = 1'b0, moving = 1'b0, alarm = 1'b0, hot = 1'b0;
  logic aux, door_open_status, door_closed_status, sko, skc, oreq, trq, hold, moff, e;
  door_in_s din;
  logic [31:0] exp_q[$], msk_q[$];
  int failures = 0, n_compared = 0, r;
  always #20 clk = ~clk;
  assign din = {opn, cls, 1'b0, end_stop, moving, alarm, hot};
  lift_ctrl_model u_mlc (.clk_i(clk), .rst_n_i(rst_n), .parked_i(parked),
    .want_open_i(want_open), .open_cmd_o(opn), .close_cmd_o(cls));
  // a short second keeps the parking delay inside the run
  door_output_park #(.TICK_CYC(8)) u_dut (.CLK_I(clk),
    .RESET_N_I(rst_n), .CE_I(1'b1),
    .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hf),
    .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .DOOR_I(din),
    .POSITION_I(pos), .LEARNED_OPEN_I(12'd1000), .AUX_RELAY_OUTPUT_O(aux),
    .DOOR_OPEN_STATUS_O(door_open_status), .DOOR_CLOSED_STATUS_O(door_closed_status),
    .SKATE_OPEN_REQ_O(sko), .SKATE_CLOSE_REQ_O(skc), .OPEN_REQ_O(oreq),
    .PARK_TORQUE_O(trq), .HOLD_LOOP_O(hold), .MOTOR_OFF_O(moff));
  // ===========================================================
  // report
  task automatic fail(input string msg);
    failures++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic got, input logic want, input string s);
    n_compared++;
    if (got !== want) begin
      fail(s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // close, withdraw it and let the 5 s delay of 8 cycles each run out
  task automatic enter_skate(input logic [11:0] p);
    parked <= 1'b0;
    tick(4);
    parked <= 1'b1;
    tick(42);
    chk(sko, 1'b0, "skate opened before the delay");
    tick(3);
    chk(sko, 1'b1, "skate opening after the delay");
    chk(door_closed_status, 1'b1, "closed status while skate opens");
    pos <= p;
    tick(3);
  endtask
  // ===========================================================
  // bus master
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      fail("bus timeout");
      tally_and_finish();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, m);
    exp_q.push_back(x);
    msk_q.push_back(m);
    wb(1'b0, a, 32'h0);
  endtask
  // read data is taken at the ack edge, oldest note first
  always @(posedge clk) begin
    if (ack === 1'b1 && cyc && !we) begin
      if (exp_q.size() == 0) begin
        fail("read without a note");
      end else begin
        n_compared++;
        if ((rdat & msk_q[0]) !== exp_q[0]) begin
          fail($sformatf("read %h want %h", rdat, exp_q[0]));
        end
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
  end
  initial begin
    #(60000 * 40);
    fail("run timeout");
    tally_and_finish();
  end
  // ===========================================================
  // scenarios
  initial begin
    void'($urandom(90013));
    tick(2);
    rst_n <= 1'b1;
    rd(ADDR_CONFIG, 32'h7, 32'h1f);
    rd(ADDR_THRESH, 32'h00190032, 32'h003f007f);
    rd(ADDR_PARK, 32'h0a1400f0, 32'h1fff03ff);
    rd(8'h20, 32'h0, 32'hffffffff);
    wb(1'b1, ADDR_PARK, 32'h00ff0001);
    rd(ADDR_PARK, 32'h02960005, 32'h1fff03ff);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, ADDR_CONFIG, 32'h4 | m);
      for (int k = 0; k < 4; k++) begin
        r = $urandom_range(1000);
        if (r == 500) begin
          r = 501;
        end
        pos <= 12'(r);
        {moving, alarm, hot} <= 3'($urandom);
        tick(3);
        e = m == 0 ? 1'b0 : m == 1 ? moving : m == 2 ? r > 500 : alarm | hot;
        chk(aux, e, "aux relay level");
      end
    end
    {moving, alarm, hot} <= 3'h0;
    wb(1'b1, ADDR_THRESH, 32'h00050032);
    wb(1'b1, ADDR_CONFIG, 32'h3);
    pos <= 12'd1000;
    end_stop <= 1'b1;
    tick(3);
    chk(door_open_status, 1'b0, "open status with no command");
    wb(1'b1, ADDR_CONFIG, 32'h7);
    pos <= 12'd994;
    tick(3);
    chk(door_open_status, 1'b0, "open status below zone");
    pos <= 12'd995;
    tick(3);
    chk(door_open_status, 1'b1, "open status at zone edge");
    end_stop <= 1'b0;
    pos <= 12'd1000;
    tick(3);
    chk(door_open_status, 1'b0, "open status without end stop");
    pos <= 12'h000;
    wb(1'b1, ADDR_CONFIG, 32'h3);
    want_open <= 1'b1;
    tick(3);
    pos <= 12'd1000;
    end_stop <= 1'b1;
    tick(3);
    chk(door_open_status, 1'b1, "open status with command");
    chk(oreq, 1'b1, "open request");
    want_open <= 1'b0;
    pos <= 12'h000;
    end_stop <= 1'b0;
    parked <= 1'b0;
    wb(1'b1, ADDR_CONFIG, 32'hf);
    tick(6);
    chk(trq, 1'b1, "parking torque");
    chk(door_closed_status, 1'b1, "closed status");
    parked <= 1'b1;
    tick(4);
    rd(ADDR_STATUS, 32'h12, 32'h7fff);
    parked <= 1'b0;
    tick(4);
    rd(ADDR_STATUS, 32'h11, 32'h7fff);
    parked <= 1'b1;
    tick(4);
    want_open <= 1'b1;
    tick(3);
    chk(trq, 1'b0, "torque after open command");
    chk(oreq, 1'b1, "open request from parking");
    want_open <= 1'b0;
    tick(2);
    enter_skate(12'd150);
    chk(moff, 1'b1, "motor off in open skate parking");
    chk(hold, 1'b0, "hold loop with free panels");
    wb(1'b1, ADDR_CONFIG, 32'h1f);
    tick(2);
    chk(hold, 1'b1, "hold loop in open skate parking");
    chk(moff, 1'b0, "motor off with hold loop");
    parked <= 1'b0;
    tick(4);
    chk(skc, 1'b1, "skate closing from open skate");
    chk(hold, 1'b0, "hold loop while skate closing");
    pos <= 12'h000;
    tick(3);
    chk(trq, 1'b1, "torque after skate closing");
    chk(skc, 1'b0, "skate closing once closed");
    enter_skate(12'd10);
    parked <= 1'b0;
    tick(4);
    chk(sko, 1'b0, "skate opening kept after close");
    chk(skc, 1'b1, "skate closing after close");
    pos <= 12'h000;
    tick(3);
    enter_skate(12'd150);
    pos <= 12'd152;
    tick(3);
    chk(door_closed_status, 1'b1, "closed status inside error limit");
    pos <= 12'd153;
    tick(3);
    chk(door_closed_status, 1'b0, "closed status after push open");
    chk(hold, 1'b0, "hold loop after push open");
    rd(ADDR_STATUS, 32'h6, 32'h1f);
    parked <= 1'b0;
    tick(4);
    pos <= 12'h000;
    tick(4);
    chk(door_closed_status, 1'b1, "closed status after new close");
    tally_and_finish();
  end
endmodule
